/* File: pkg/sld_pkg.sv */
// Package of constants for the supply level detector control block
package sld_pkg;
   // Register byte offsets on the AHB-Lite bus
   localparam logic [7:0] SLD_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] SLD_STAT_OFFSET = 8'h04;
   // Control register field positions
   localparam int SLD_CTRL_RANGE_BIT = 3;
   localparam int SLD_CTRL_TRIM_LSB = 0;
   localparam int SLD_TRIM_WIDTH = 3;
   // Status register field positions
   localparam int SLD_STAT_EN_BIT = 0;
   localparam int SLD_STAT_VALID_BIT = 1;
   localparam int SLD_STAT_BELOW_BIT = 2;
   // Reset values
   localparam logic [7:0] SLD_CTRL_RESET = 8'h00;
   localparam logic [7:0] SLD_STAT_RESET = 8'h00;
   // Settling interval
   localparam int SLD_CLK_MHZ = 100;
   localparam int SLD_SETTLE_US = 2000;
   localparam int SLD_SETTLE_CYCLES = SLD_SETTLE_US * SLD_CLK_MHZ;
   // HTRANS codes
   localparam logic [1:0] SLD_HTRANS_NONSEQ = 2'h2;
   // Detector sequencing states
   typedef enum logic [2:0] {
      SLD_OFF = 3'h1,
      SLD_SETTLE = 3'h2,
      SLD_VALID = 3'h4
   } sld_state_e;
endpackage

/* File: design/sld_edge_det.sv */
// Rising edge detector with enable qualifier
`timescale 1ns/10ps
`default_nettype none
module sld_edge_det (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic arm_in,
   input wire logic level_in,
   output logic rise_out
);
   logic prev_ff;

   // Remember the last level; cleared while not armed so a high level on arming counts
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prev_ff <= 1'b0;
      end else if (!arm_in) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level_in;
      end
   end

   // Pulse on a zero to one step
   assign rise_out = arm_in && level_in && !prev_ff;
endmodule
`default_nettype wire

/* File: design/sld_ctrl.sv */
// Supply level detector control and status block with AHB-Lite slave
// Function
// - Enable bit turns detector on or off
// - Valid flag set after 2 ms settling
// - Interrupt while valid and enabled on low
// - One request per rising below-threshold edge
// - Status bit 2 reads below-threshold result
// - Status bit 1 reads valid flag
// - Control bit 3 range select, reset zero
// - Control bits 2-0 trim code, reset zero
`timescale 1ns/10ps
`default_nettype none
module sld_ctrl
   import sld_pkg::*;
#(
   parameter int SETTLE_CYCLES = SLD_SETTLE_CYCLES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic comparator_below_in,
   output logic detector_enable_out,
   output logic threshold_range_sel_out,
   output logic [2:0] threshold_trim_code_out,
   output logic low_supply_irq_out
);
   logic [7:0] ctrl_ff;
   logic detector_enable_ff;
   logic result_valid_flag_ff;
   logic below_threshold_flag_ff;
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] hrdata_ff;
   logic [31:0] cnt_ff;
   sld_state_e state_ff;
   sld_state_e nxt_state;
   logic addr_phase;
   logic rise;
   logic [7:0] nxt_ctrl;
   logic nxt_detector_enable;

   // Accept a transfer when selected, active and the bus is ready
   assign addr_phase = hsel_in && hready_in && htrans_in[1];
   // The slave never waits and always answers OKAY; every register is a flop
   // behind a short decode, so no access ever needs a wait state
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   // Latch write address for the data phase
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= addr_phase && hwrite_in;
         wr_addr_ff <= haddr_in[7:0];
      end
   end

   // Register values as they stand once a pending write lands. A read taken in
   // the data phase of a write to the same register sees the new value, so
   // back-to-back transfers never return stale data.
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_detector_enable = detector_enable_ff;
      if (wr_pend_ff && wr_addr_ff == SLD_CTRL_OFFSET) begin
         nxt_ctrl = {4'h0, hwdata_in[3:0]};
      end else if (wr_pend_ff && wr_addr_ff == SLD_STAT_OFFSET) begin
         nxt_detector_enable = hwdata_in[SLD_STAT_EN_BIT];
      end
   end

   // Read data registered at the address phase; unmapped reads give zero
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hrdata_ff <= 32'h00000000;
      end else if (addr_phase && !hwrite_in) begin
         if (haddr_in[7:0] == SLD_CTRL_OFFSET) begin
            hrdata_ff <= {24'h000000, nxt_ctrl};
         end else if (haddr_in[7:0] == SLD_STAT_OFFSET) begin
            hrdata_ff <= {29'h00000000, below_threshold_flag_ff,
                          result_valid_flag_ff, nxt_detector_enable};
         end else begin
            hrdata_ff <= 32'h00000000;
         end
      end
   end
   assign hrdata_out = hrdata_ff;

   // Control register: only range and trim bits are stored, the rest reads zero
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_ff <= SLD_CTRL_RESET;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end
   assign threshold_range_sel_out = ctrl_ff[SLD_CTRL_RANGE_BIT];
   assign threshold_trim_code_out = ctrl_ff[SLD_TRIM_WIDTH-1:SLD_CTRL_TRIM_LSB];

   // Enable bit in the status register, written by software; the valid and
   // result bits of the same register are read-only and ignore the write
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         detector_enable_ff <= 1'b0;
      end else begin
         detector_enable_ff <= nxt_detector_enable;
      end
   end
   assign detector_enable_out = detector_enable_ff;

   // Sequencing: off, settling, valid
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SLD_OFF: begin
            if (detector_enable_ff) begin
               nxt_state = SLD_SETTLE;
            end
         end
         SLD_SETTLE: begin
            if (!detector_enable_ff) begin
               nxt_state = SLD_OFF;
            end else if (cnt_ff == 32'(SETTLE_CYCLES - 1)) begin
               nxt_state = SLD_VALID;
            end
         end
         SLD_VALID: begin
            if (!detector_enable_ff) begin
               nxt_state = SLD_OFF;
            end
         end
         default: begin
            nxt_state = SLD_OFF;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff <= SLD_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Settling counter, restarted on each entry to settling; 32 bits cover the
   // whole settling span at any realistic system clock
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_ff <= 32'h00000000;
      end else if (state_ff == SLD_SETTLE) begin
         cnt_ff <= cnt_ff + 32'h00000001;
      end else begin
         cnt_ff <= 32'h00000000;
      end
   end

   // Valid flag follows the state
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         result_valid_flag_ff <= 1'b0;
      end else begin
         result_valid_flag_ff <= (nxt_state == SLD_VALID);
      end
   end

   // Result sampled only while enabled; cleared when off
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         below_threshold_flag_ff <= 1'b0;
      end else if (detector_enable_ff) begin
         below_threshold_flag_ff <= comparator_below_in;
      end else begin
         below_threshold_flag_ff <= 1'b0;
      end
   end

   // Rising edge of the result, armed only while valid
   sld_edge_det u_edge (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .arm_in(result_valid_flag_ff && detector_enable_ff),
      .level_in(below_threshold_flag_ff),
      .rise_out(rise)
   );

   // One-cycle request pulse, registered
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         low_supply_irq_out <= 1'b0;
      end else begin
         low_supply_irq_out <= rise;
      end
   end

   // Checks on sequencing, request line and register reads, on the system clock

   // Last settling cycle with the detector still enabled
   sequence s_settle_done;
      state_ff == SLD_SETTLE && cnt_ff == 32'(SETTLE_CYCLES - 1) && detector_enable_ff;
   endsequence

   // Software has just switched the detector on
   sequence s_enable_rise;
      $rose(detector_enable_ff);
   endsequence

   // Validity arrives while the supply is already below the threshold
   sequence s_valid_arrives_low;
      !result_valid_flag_ff ##1
         result_valid_flag_ff && detector_enable_ff && below_threshold_flag_ff;
   endsequence

   // Valid follows the last settling cycle
   a_valid_after_settle: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      s_settle_done |=> result_valid_flag_ff)
      else $error("valid flag not set after settling");

   // Valid never rises before the full settling count has run
   a_valid_needs_time: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(result_valid_flag_ff) |-> cnt_ff == 32'(SETTLE_CYCLES))
      else $error("valid flag rose early");

   // Every enable restarts settling from a zero count
   a_settle_restart: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      s_enable_rise |=> state_ff == SLD_SETTLE && cnt_ff == 32'h00000000)
      else $error("settling did not restart");

   // Disabling drops both flags
   a_disable_clears: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !detector_enable_ff |=> !result_valid_flag_ff && !below_threshold_flag_ff)
      else $error("disable did not clear flags");

   // A disabled detector never raises a request
   a_no_irq_disabled: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !detector_enable_ff |=> !low_supply_irq_out)
      else $error("request from disabled detector");

   // The result bit follows the comparator one cycle later while enabled
   a_below_follows: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      detector_enable_ff |=> below_threshold_flag_ff == $past(comparator_below_in))
      else $error("result bit does not follow comparator");

   // Requests only come from a valid, enabled detector
   a_irq_only_enabled: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      low_supply_irq_out |-> $past(result_valid_flag_ff) && $past(detector_enable_ff))
      else $error("request while not valid");

   // A request needs a below result behind it
   a_irq_on_rise: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      low_supply_irq_out |-> $past(below_threshold_flag_ff))
      else $error("request without below result");

   // Each request is a single-cycle pulse
   a_irq_single: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      low_supply_irq_out |=> !low_supply_irq_out)
      else $error("request longer than one cycle");

   // A falling result never gives a request
   a_irq_no_fall: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $fell(below_threshold_flag_ff) |=> !low_supply_irq_out)
      else $error("request on falling result");

   // Reserved control bits are never stored
   a_reserved_zero: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      ctrl_ff[7:4] == 4'h0)
      else $error("reserved control bits set");

   // A rising result while valid gives a request on the next cycle
   a_rise_gives_irq: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      result_valid_flag_ff && detector_enable_ff && $rose(below_threshold_flag_ff)
      |=> low_supply_irq_out)
      else $error("missed request on rising result");

   // A result already low when validity arrives counts as one rising edge
   a_irq_on_arming: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      s_valid_arrives_low |=> low_supply_irq_out)
      else $error("missed request at validity");

   // Control reads return zero above the four stored bits
   a_ctrl_read_upper: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      addr_phase && !hwrite_in && haddr_in[7:0] == SLD_CTRL_OFFSET
      |=> hrdata_out[31:4] == 28'h0000000)
      else $error("control read shows reserved bits");

   // Status reads return zero above the three status bits
   a_stat_read_upper: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      addr_phase && !hwrite_in && haddr_in[7:0] == SLD_STAT_OFFSET
      |=> hrdata_out[31:3] == 29'h00000000)
      else $error("status read shows reserved bits");

   // A control write reaches the range and trim outputs
   a_setting_write: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      wr_pend_ff && wr_addr_ff == SLD_CTRL_OFFSET
      |=> {threshold_range_sel_out, threshold_trim_code_out} == $past(hwdata_in[3:0]))
      else $error("range or trim output not updated");
endmodule
`default_nettype wire

/* File: testbench/sld_ctrl_tb_top.sv */
// Self-checking testbench for the supply level detector control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin \
   samples_checked++; \
   if ((s) !== (e)) begin \
      err_count++; \
      $display("Error %s exp %h got %h", n, e, s); \
   end \
end
module sld_ctrl_tb_top;
   import sld_pkg::*;
   localparam int ST = 20;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} sld_row_s;
   logic clk_in, resetn_in, hsel, hwrite, comp, hrdy, hresp, en, rng, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] trim;
   int err_count = 0;
   int samples_checked = 0;
   int irq_cnt = 0;
   // Write a value, read it back: reserved bits and unmapped space read zero
   sld_row_s rows [6] = '{
      '{SLD_CTRL_OFFSET, 32'hffff_ffff, 32'h0000_000f},
      '{SLD_CTRL_OFFSET, 32'h0000_0005, 32'h0000_0005},
      '{SLD_CTRL_OFFSET, 32'h0000_00f0, 32'h0000_0000},
      '{8'h08, 32'hffff_ffff, 32'h0000_0000},
      '{SLD_STAT_OFFSET, 32'h0000_00fe, 32'h0000_0000},
      '{SLD_CTRL_OFFSET, 32'h0000_0000, 32'h0000_0000}};

   sld_ctrl #(.SETTLE_CYCLES(ST)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
      .hreadyout_out(hrdy), .hresp_out(hresp), .comparator_below_in(comp),
      .detector_enable_out(en), .threshold_range_sel_out(rng),
      .threshold_trim_code_out(trim), .low_supply_irq_out(irq));

   // Clock at 100 MHz
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Count interrupt pulses; any other level than a clean low is a mismatch
   always @(posedge clk_in) begin
      if (irq === 1'b1) begin
         irq_cnt++;
      end else begin
         `CHK("irq_level", 1'b0, irq)
      end
   end

   // One AHB-Lite single transfer, waiting on hready in both phases
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= SLD_HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge clk_in);
      while (hrdy !== 1'b1) @(posedge clk_in);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_in);
      while (hrdy !== 1'b1) @(posedge clk_in);
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK("rdata", e, rd)
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic finish_test();
      $display("Checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      wait_clk(5000);
      err_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      comp = 1'b0;
      resetn_in = 1'b0;
      wait_clk(6);
      resetn_in <= 1'b1;
      rdchk(SLD_CTRL_OFFSET, 32'h0);
      rdchk(SLD_STAT_OFFSET, 32'h0);
      foreach (rows[i]) begin
         xfer(1'b1, rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].e);
      end
      // Every trim step reaches the analog side
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, SLD_CTRL_OFFSET, 32'(i));
         wait_clk(1);
         `CHK("trim", 3'(i), trim)
      end
      xfer(1'b1, SLD_CTRL_OFFSET, 32'h8);
      wait_clk(1);
      `CHK("range", 1'b1, rng)
      // Disabled detector ignores a low supply
      comp <= 1'b1;
      wait_clk(ST + 5);
      `CHK("irq_off", 0, irq_cnt)
      rdchk(SLD_STAT_OFFSET, 32'h0);
      comp <= 1'b0;
      // Range and trim stay untouched from here on while the detector runs
      xfer(1'b1, SLD_STAT_OFFSET, 32'h1);
      wait_clk(1);
      `CHK("enable", 1'b1, en)
      rdchk(SLD_STAT_OFFSET, 32'h1);
      wait_clk(ST + 4);
      rdchk(SLD_STAT_OFFSET, 32'h3);
      comp <= 1'b1;
      wait_clk(4);
      `CHK("irq_rise", 1, irq_cnt)
      rdchk(SLD_STAT_OFFSET, 32'h7);
      comp <= 1'b0;
      wait_clk(4);
      `CHK("irq_fall", 1, irq_cnt)
      rdchk(SLD_STAT_OFFSET, 32'h3);
      comp <= 1'b1;
      wait_clk(4);
      `CHK("irq_again", 2, irq_cnt)
      // Disable then re-enable restarts settling
      xfer(1'b1, SLD_STAT_OFFSET, 32'h0);
      rdchk(SLD_STAT_OFFSET, 32'h0);
      `CHK("irq_dis", 2, irq_cnt)
      comp <= 1'b0;
      xfer(1'b1, SLD_STAT_OFFSET, 32'hff);
      rdchk(SLD_STAT_OFFSET, 32'h1);
      wait_clk(ST + 4);
      rdchk(SLD_STAT_OFFSET, 32'h3);
      // A supply already low when validity arrives gives one request
      xfer(1'b1, SLD_STAT_OFFSET, 32'h0);
      comp <= 1'b1;
      xfer(1'b1, SLD_STAT_OFFSET, 32'h1);
      wait_clk(ST + 6);
      `CHK("irq_arm", 3, irq_cnt)
      rdchk(SLD_STAT_OFFSET, 32'h7);
      // Reset in mid-run clears every register
      comp <= 1'b0;
      resetn_in <= 1'b0;
      wait_clk(2);
      `CHK("en_rst", 1'b0, en)
      `CHK("rng_rst", 1'b0, rng)
      resetn_in <= 1'b1;
      rdchk(SLD_CTRL_OFFSET, 32'h0);
      rdchk(SLD_STAT_OFFSET, 32'h0);
      `CHK("irq_total", 3, irq_cnt)
      finish_test();
   end
endmodule
`default_nettype wire
